//--- hw/sscg_pkg.sv
package sscg_pkg;

   localparam int unsigned CLK_HZ            = 20_000_000;
   localparam int unsigned RESET_TIMEOUT_MS  = 150;
   localparam int unsigned WATCHDOG_MS       = 1600;
   localparam int unsigned CE_HOLD_US        = 12;
   localparam int unsigned DEBOUNCE_MS       = 1;
   localparam int unsigned WD_PULSE_NS       = 100;

   localparam int unsigned RESET_TIMEOUT_CYC = (CLK_HZ / 1000) * RESET_TIMEOUT_MS;
   localparam int unsigned WATCHDOG_CYC      = (CLK_HZ / 1000) * WATCHDOG_MS;
   localparam int unsigned CE_HOLD_CYC       = (CLK_HZ / 1_000_000) * CE_HOLD_US;
   localparam int unsigned DEBOUNCE_CYC      = (CLK_HZ / 1000) * DEBOUNCE_MS;
   localparam int unsigned WD_PULSE_CYC      = ((CLK_HZ / 1_000_000) * WD_PULSE_NS + 999) / 1000;

   localparam logic        RST_ACTIVE_LOW    = 1'b1;

   typedef struct packed {
      logic supply_below_threshold;
      logic supply_below_battery;
      logic backup_battery_in;
      logic manual_reset_n;
      logic aux_reset_low;
      logic watchdog_kick_in;
      logic chip_enable_in_n;
   } sscg_pins_t;

   typedef enum logic [1:0] {
      SSCG_CE_PASS,
      SSCG_CE_HOLD_LOW,
      SSCG_CE_FORCE_HIGH
   } sscg_ce_state_t;

endpackage : sscg_pkg

//--- hw/sscg_sync.sv
`timescale 1ns/1ns
module sscg_sync
   import sscg_pkg::*;
#(
   parameter int unsigned     WIDTH       = 7,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input  wire logic             sys_clk,
   input  wire logic             arst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   initial begin
      if (WIDTH < 1) begin
         $error("sscg_sync needs WIDTH of at least one");
      end
   end

   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   // The reset value is a constant per bit, chosen at the instance.
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
               meta_q[gi] <= RESET_VALUE[gi];
               sync_q[gi] <= RESET_VALUE[gi];
            end else begin
               meta_q[gi] <= meta_d[gi];
               sync_q[gi] <= sync_d[gi];
            end
         end
      end
   endgenerate

   assign sync_out = sync_q;

endmodule : sscg_sync

//--- hw/sscg_debounce.sv
`timescale 1ns/1ns
module sscg_debounce
   import sscg_pkg::*;
#(
   parameter int unsigned STABLE_CYC = DEBOUNCE_CYC
) (
   input  wire logic sys_clk,
   input  wire logic arst_n,
   input  wire logic raw_in,
   output logic      clean_out
);

   localparam int unsigned CW = $clog2(STABLE_CYC + 1);

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic          level_q;
   logic          level_d;

   initial begin
      if (STABLE_CYC < 1) begin
         $error("sscg_debounce needs STABLE_CYC of at least one");
      end
   end

   // A bouncing contact only flips the output after it has held still.
   always_comb begin
      cnt_d   = cnt_q;
      level_d = level_q;
      if (raw_in == level_q) begin
         cnt_d = '0;
      end else if (cnt_q >= CW'(STABLE_CYC - 1)) begin
         cnt_d   = '0;
         level_d = raw_in;
      end else begin
         cnt_d = cnt_q + CW'(1);
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q   <= '0;
         level_q <= 1'b1;
      end else begin
         cnt_q   <= cnt_d;
         level_q <= level_d;
      end
   end

   assign clean_out = level_q;

endmodule : sscg_debounce

//--- hw/sscg_supervisor.sv
`timescale 1ns/1ns
// Behaviour
// R1: Battery mode only when supply is below threshold and below battery; then output backed.
// R2: Outside reset, chip-enable output follows the chip-enable input.
// R3: Input high at reset start keeps output high for the whole event.
// R4: Input low at reset start holds output low 12us, then high.
// R5: Output not following the input is driven inactive high.
// R6: Battery mode forces reset, ignores inputs, holds chip-enable output high.
// R7: Battery-mode flag is high exactly while in battery mode.
// R8: Start only from main supply, never from battery alone.
// R9: Low manual reset asserts reset, held 150ms after release.
// R10: Manual reset input is debounced internally.
// R11: Each watchdog input edge, or pulse of 100ns, restarts the watchdog.
// R12: Watchdog input stuck past timeout triggers one reset timeout pulse.
// R13: Watchdog timer clears on reset and on any input edge.
// R14: Stuck watchdog input repeats reset pulses every watchdog timeout.
// R15: Auxiliary sense below 1.235V asserts reset.
// R16: Supply below threshold asserts reset, held 150ms after recovery.
// R17: Reset polarity is a build option, always at a defined level.
// R18: Auxiliary sense recovery keeps reset for the reset timeout.
// R19: Timeouts are counted by restartable clocked counters.
module sscg_supervisor
   import sscg_pkg::*;
#(
   parameter int unsigned RESET_CYC     = RESET_TIMEOUT_CYC,
   parameter int unsigned WATCHDOG_CYCS = WATCHDOG_CYC,
   parameter int unsigned CE_CYC        = CE_HOLD_CYC,
   parameter int unsigned DEBOUNCE_CYCS = DEBOUNCE_CYC,
   parameter logic        ACTIVE_LOW    = RST_ACTIVE_LOW
) (
   input  wire logic       sys_clk,
   input  wire logic       arst_n,
   input  wire sscg_pins_t pins_in,
   output logic            reset_out,
   output logic            chip_enable_out_n,
   output logic            backed_from_battery,
   output logic            battery_mode_flag
);

   // Counter widths follow the parameters so that shortened values for simulation still fit.
   localparam int unsigned RW = $clog2(RESET_CYC + 1);
   localparam int unsigned WW = $clog2(WATCHDOG_CYCS + 1);
   localparam int unsigned CW = $clog2(CE_CYC + 1);

   // Pins leave reset at their idle levels, so no false start, cause or kick follows reset.
   localparam sscg_pins_t PINS_IDLE = '{
      supply_below_threshold: 1'b1,
      manual_reset_n:         1'b1,
      chip_enable_in_n:       1'b1,
      default:                1'b0
   };

   initial begin
      if (RESET_CYC < 1) begin
         $error("sscg_supervisor needs RESET_CYC of at least one");
      end
      if (WATCHDOG_CYCS < 1) begin
         $error("sscg_supervisor needs WATCHDOG_CYCS of at least one");
      end
      if (CE_CYC < 1) begin
         $error("sscg_supervisor needs CE_CYC of at least one");
      end
      if (DEBOUNCE_CYCS < 1) begin
         $error("sscg_supervisor needs DEBOUNCE_CYCS of at least one");
      end
      // The chip-enable hold must end inside the shortest reset event, a watchdog pulse.
      if (CE_CYC >= RESET_CYC) begin
         $error("sscg_supervisor needs CE_CYC below RESET_CYC");
      end
   end

   sscg_pins_t pins_s;
   logic       mr_clean;

   // Every pin is an asynchronous level, so all of them pass the same two flops.
   sscg_sync #(
      .WIDTH      ($bits(sscg_pins_t)),
      .RESET_VALUE(PINS_IDLE)
   ) u_sync (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .async_in(pins_in),
      .sync_out(pins_s)
   );

   // R10: debounce manual reset
   sscg_debounce #(
      .STABLE_CYC(DEBOUNCE_CYCS)
   ) u_mr_db (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .raw_in   (pins_s.manual_reset_n),
      .clean_out(mr_clean)
   );

   // Registered state, each with its next value.
   logic           started_q;
   logic           started_d;
   logic           backup_battery_in_q;
   logic           backup_battery_in_d;
   logic [RW-1:0]  rst_cnt_q;
   logic [RW-1:0]  rst_cnt_d;
   logic           rst_q;
   logic           rst_d;
   logic [WW-1:0]  wd_cnt_q;
   logic [WW-1:0]  wd_cnt_d;
   logic           wd_prev_q;
   logic           wd_prev_d;
   logic [CW-1:0]  ce_cnt_q;
   logic [CW-1:0]  ce_cnt_d;
   sscg_ce_state_t ce_st_q;
   sscg_ce_state_t ce_st_d;
   logic           ce_out_q;
   logic           ce_out_d;
   logic           rst_pin_q;
   logic           rst_pin_d;
   logic           backed_q;
   logic           backed_d;
   logic           flag_q;
   logic           flag_d;

   // Decode signals, recomputed every cycle and never stored.
   logic hold_cond;
   logic wd_edge;
   logic wd_expire;

   // Power-up. A battery alone never starts the block, since main supply must be seen once.
   always_comb begin
      started_d = started_q;
      // R8: start from main only
      if (!pins_s.supply_below_threshold) begin
         started_d = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         started_q <= 1'b0;
      end else begin
         started_q <= started_d;
      end
   end

   // Battery mode.
   always_comb begin
      // R1: both conditions for backup
      backup_battery_in_d = started_q && pins_s.supply_below_threshold && pins_s.supply_below_battery
               && pins_s.backup_battery_in;
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         backup_battery_in_q <= 1'b0;
      end else begin
         backup_battery_in_q <= backup_battery_in_d;
      end
   end

   // Watchdog. The synchroniser sees any pulse of two clocks or more, so a 100ns kick is caught.
   always_comb begin
      // R11: any change is a kick
      wd_edge   = pins_s.watchdog_kick_in != wd_prev_q;
      wd_prev_d = pins_s.watchdog_kick_in;
      wd_expire = 1'b0;
      wd_cnt_d  = wd_cnt_q;
      // The count also rests before startup and in battery mode, when no kick can be trusted.
      // R13: clear on reset or edge
      if (rst_q || backup_battery_in_q || wd_edge || !started_q) begin
         wd_cnt_d = '0;
      // R12: timeout fires a pulse
      end else if (wd_cnt_q >= WW'(WATCHDOG_CYCS - 1)) begin
         wd_expire = 1'b1;
         wd_cnt_d  = '0;
      end else begin
         wd_cnt_d = wd_cnt_q + WW'(1);
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wd_cnt_q  <= '0;
         wd_prev_q <= 1'b0;
      end else begin
         wd_cnt_q  <= wd_cnt_d;
         wd_prev_q <= wd_prev_d;
      end
   end

   // Reset generator.
   always_comb begin
      // R16: supply low holds reset
      // R9: manual reset holds reset
      // R15: auxiliary sense holds reset
      // R6: battery mode forces reset
      hold_cond = pins_s.supply_below_threshold || !started_q || backup_battery_in_q
                  || (!backup_battery_in_q && (!mr_clean || pins_s.aux_reset_low));
      rst_cnt_d = rst_cnt_q;
      rst_d     = rst_q;
      // Hold the count at zero while any cause stands, so the timeout runs from the last release.
      // R19: counter restarts on cause
      // R14: each expiry restarts pulse
      if (hold_cond || wd_expire) begin
         rst_d     = 1'b1;
         rst_cnt_d = '0;
      // R18: timeout after release
      end else if (rst_q) begin
         if (rst_cnt_q >= RW'(RESET_CYC - 1)) begin
            rst_d     = 1'b0;
            rst_cnt_d = '0;
         end else begin
            rst_cnt_d = rst_cnt_q + RW'(1);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_cnt_q <= '0;
         rst_q     <= 1'b1;
      end else begin
         rst_cnt_q <= rst_cnt_d;
         rst_q     <= rst_d;
      end
   end

   // Chip-enable gate.
   always_comb begin
      ce_st_d  = ce_st_q;
      ce_cnt_d = ce_cnt_q;
      ce_out_d = 1'b1;
      // The input level in the cycle that reset rises decides between hold and force.
      case (ce_st_q)
         SSCG_CE_PASS: begin
            if (rst_d) begin
               // R3: high input stays high
               ce_st_d  = SSCG_CE_FORCE_HIGH;
               ce_cnt_d = '0;
               // R4: low input held low
               if (!pins_s.chip_enable_in_n && !backup_battery_in_d) begin
                  ce_st_d  = SSCG_CE_HOLD_LOW;
                  ce_out_d = 1'b0;
               end
            end else begin
               // R2: pass the input
               ce_out_d = pins_s.chip_enable_in_n;
            end
         end
         SSCG_CE_HOLD_LOW: begin
            ce_out_d = 1'b0;
            ce_cnt_d = ce_cnt_q + CW'(1);
            if (backup_battery_in_d || ce_cnt_q >= CW'(CE_CYC - 1)) begin
               ce_st_d  = SSCG_CE_FORCE_HIGH;
               ce_out_d = 1'b1;
            end
         end
         default: begin
            // R5: drive inactive high
            ce_out_d = 1'b1;
            if (!rst_d) begin
               ce_st_d  = SSCG_CE_PASS;
               ce_out_d = pins_s.chip_enable_in_n;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ce_st_q  <= SSCG_CE_FORCE_HIGH;
         ce_cnt_q <= '0;
         ce_out_q <= 1'b1;
      end else begin
         ce_st_q  <= ce_st_d;
         ce_cnt_q <= ce_cnt_d;
         ce_out_q <= ce_out_d;
      end
   end

   // Output stage. Each pin leaves a flop, so the processor never sees a decode glitch.
   always_comb begin
      // R17: selectable polarity
      rst_pin_d = ACTIVE_LOW ? !rst_d : rst_d;
      // R7: flag follows battery mode
      flag_d    = backup_battery_in_d;
      // R1: backed output switches
      backed_d  = backup_battery_in_d;
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_pin_q <= !ACTIVE_LOW;
         backed_q  <= 1'b0;
         flag_q    <= 1'b0;
      end else begin
         rst_pin_q <= rst_pin_d;
         backed_q  <= backed_d;
         flag_q    <= flag_d;
      end
   end

   assign reset_out           = rst_pin_q;
   assign chip_enable_out_n   = ce_out_q;
   assign backed_from_battery = backed_q;
   assign battery_mode_flag   = flag_q;

endmodule : sscg_supervisor

//--- verification/sscg_supervisor_checker.sv
`timescale 1ns/1ns
module sscg_supervisor_checker
   import sscg_pkg::*;
#(
   parameter int unsigned RESET_CYC     = RESET_TIMEOUT_CYC,
   parameter int unsigned WATCHDOG_CYCS = WATCHDOG_CYC,
   parameter int unsigned CE_CYC        = CE_HOLD_CYC,
   parameter int unsigned DEBOUNCE_CYCS = DEBOUNCE_CYC,
   parameter logic        ACTIVE_LOW    = RST_ACTIVE_LOW
) (
   input wire logic       sys_clk,
   input wire logic       arst_n,
   input wire sscg_pins_t pins_in,
   input wire logic       reset_out,
   input wire logic       chip_enable_out_n,
   input wire logic       backed_from_battery,
   input wire logic       battery_mode_flag
);
   localparam logic [31:0] ONE = 32'h0000_0001;
   logic        act;
   logic        kick_q;
   logic [31:0] rst_q, rst_d, lo_q, lo_d, wd_q, wd_d, mr_q, mr_d;
   assign act = reset_out ^ ACTIVE_LOW;
   // The kick counter restarts on either edge, so a held level is what it measures.
   always_comb begin
      rst_d = act ? rst_q + ONE : '0;
      lo_d  = act ? lo_q + {31'h0, !chip_enable_out_n} : '0;
      wd_d  = (act || pins_in.watchdog_kick_in != kick_q) ? '0 : wd_q + ONE;
      mr_d  = pins_in.manual_reset_n ? '0 : mr_q + ONE;
   end
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_q  <= '0;
         lo_q   <= '0;
         wd_q   <= '0;
         mr_q   <= '0;
         kick_q <= 1'b0;
      end else begin
         rst_q  <= rst_d;
         lo_q   <= lo_d;
         wd_q   <= wd_d;
         mr_q   <= mr_d;
         kick_q <= pins_in.watchdog_kick_in;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   chk_flag_backed: assert property (battery_mode_flag == backed_from_battery)
      else $error("battery flag and backing differ");
   chk_backup_battery_in_cause: assert property (battery_mode_flag |->
      $past(pins_in.supply_below_threshold, 3) && $past(pins_in.supply_below_battery, 3))
      else $error("battery mode without cause");
   chk_backup_battery_in_forces: assert property (battery_mode_flag |-> act && chip_enable_out_n)
      else $error("battery mode not forcing outputs");
   chk_ce_pass: assert property ((!act) [*4] |-> chip_enable_out_n == $past(pins_in.chip_enable_in_n, 3))
      else $error("chip enable not passed");
   chk_ce_stays: assert property (act && $past(act) && $past(chip_enable_out_n) |-> chip_enable_out_n)
      else $error("chip enable left high state");
   chk_ce_hold: assert property (lo_q <= CE_CYC + 1)
      else $error("chip enable held low too long");
   chk_reset_min: assert property ($fell(act) |-> rst_q >= RESET_CYC)
      else $error("reset released too early");
   chk_supply_rst: assert property (pins_in.supply_below_threshold [*5] |-> act)
      else $error("low supply without reset");
   chk_aux_rst: assert property (pins_in.aux_reset_low [*5] |-> act)
      else $error("aux sense without reset");
   chk_mr_rst: assert property (mr_q > DEBOUNCE_CYCS + 6 |-> act)
      else $error("manual reset ignored");
   chk_wd_bound: assert property (wd_q <= WATCHDOG_CYCS + 6)
      else $error("watchdog did not expire");
   cov_backup_battery_in: cover property (battery_mode_flag);
   cov_hold: cover property (act && !chip_enable_out_n);
   cov_wd: cover property (wd_q == WATCHDOG_CYCS);
endmodule : sscg_supervisor_checker

bind sscg_supervisor sscg_supervisor_checker #(.RESET_CYC(RESET_CYC), .WATCHDOG_CYCS(WATCHDOG_CYCS),
   .CE_CYC(CE_CYC), .DEBOUNCE_CYCS(DEBOUNCE_CYCS), .ACTIVE_LOW(ACTIVE_LOW)) i_chk (.sys_clk(sys_clk),
   .arst_n(arst_n), .pins_in(pins_in), .reset_out(reset_out), .chip_enable_out_n(chip_enable_out_n),
   .backed_from_battery(backed_from_battery), .battery_mode_flag(battery_mode_flag));

//--- verification/sscg_partner.sv
`timescale 1ns/1ns
module sscg_partner
#(
   parameter int unsigned KICK_CYC = 10
) (
   input  wire logic sys_clk,
   input  wire logic kick_en,
   input  wire logic ce_cmd_n,
   output logic      watchdog_kick_in,
   output logic      chip_enable_in_n
);
   int   n;
   logic en;
   logic cmd;
   // Commands are taken at the edge, so the model never races the bench that drives them.
   initial begin
      n = 0;
      watchdog_kick_in = 1'b0;
      chip_enable_in_n = 1'b1;
      forever begin
         @(posedge sys_clk);
         en  = kick_en;
         cmd = ce_cmd_n;
         #2;
         chip_enable_in_n = cmd;
         n = en ? n + 1 : 0;
         // spaced level toggles
         // Levels stay far above two clocks so the synchroniser sees every kick.
         if (n >= KICK_CYC) begin
            watchdog_kick_in = !watchdog_kick_in;
            n = 0;
         end
      end
   end
endmodule : sscg_partner

//--- verification/supply_supervisor_reset_ce_gate_tb.sv
`timescale 1ns/1ns
module supply_supervisor_reset_ce_gate_tb
   import sscg_pkg::*;
;
   localparam int unsigned RC = 20;
   localparam int unsigned WC = 50;
   localparam int unsigned CC = 4;
   localparam int unsigned DC = 3;
   logic       sys_clk, arst_n, kick_en, ce_cmd_n, wd, ce_in_n, sup, blo, bat, mr_n, aux;
   logic       reset_out, ce_out_n, backed, flag, act;
   sscg_pins_t pins;
   int         fail_count, num_checks, n, k, hold, lo;
   int         causes[$];
   assign act = reset_out ^ RST_ACTIVE_LOW;
   assign pins = {sup, blo, bat, mr_n, aux, wd, ce_in_n};
   sscg_supervisor #(.RESET_CYC(RC), .WATCHDOG_CYCS(WC), .CE_CYC(CC), .DEBOUNCE_CYCS(DC)) i_dut (
      .sys_clk(sys_clk), .arst_n(arst_n), .pins_in(pins), .reset_out(reset_out),
      .chip_enable_out_n(ce_out_n), .backed_from_battery(backed), .battery_mode_flag(flag));
   sscg_partner i_cpu (.sys_clk(sys_clk), .kick_en(kick_en), .ce_cmd_n(ce_cmd_n),
      .watchdog_kick_in(wd), .chip_enable_in_n(ce_in_n));
   task automatic step(input int c);
      repeat (c) @(posedge sys_clk);
      #2;
   endtask : step
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected at %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic rel_len(output int c);
      c = 0;
      while (act === 1'b1 && c < 5000) begin
         step(1);
         c++;
      end
   endtask : rel_len
   task report_and_stop;
      if (fail_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : report_and_stop
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      report_and_stop();
   end
   initial begin
      n = $urandom(32'h1552_1a40);
      {fail_count, num_checks, arst_n, kick_en, aux} = '0;
      {ce_cmd_n, sup, blo, bat, mr_n} = 5'h1f;
      step(5);
      arst_n = 1'b1;
      kick_en = 1'b1;
      step(10);
      chk({flag, act}, 2'h1);
      {sup, blo} = 2'h0;
      rel_len(n);
      chk(n >= RC && n <= RC + 8, 1'h1);
      mr_n = 1'b0;
      step(1);
      mr_n = 1'b1;
      for (k = 0; k < 10; k++) begin
         step(1);
         chk(act, 1'h0);
      end
      causes = '{0, 1, 2, 0, 1, 2};
      foreach (causes[i]) begin
         ce_cmd_n = i[0];
         step(5);
         chk(ce_out_n, ce_cmd_n);
         {sup, aux, mr_n} = {causes[i] == 0, causes[i] == 1, causes[i] != 2};
         lo = 0;
         hold = CC + 12 + $urandom_range(15);
         for (k = 0; k < hold; k++) begin
            step(1);
            if (k > CC + 10)
               ce_cmd_n = 1'($urandom);
            lo += act && !ce_out_n;
         end
         chk(act, 1'h1);
         chk(i[0] ? lo == 0 : lo >= CC && lo <= CC + 1, 1'h1);
         {sup, aux, mr_n} = 3'h1;
         rel_len(n);
         chk(n >= RC && n <= RC + DC + 8, 1'h1);
      end
      kick_en = 1'b0;
      for (k = 0; k < 2; k++) begin
         n = 0;
         while (act !== 1'b1 && n < WC + 20) begin
            step(1);
            n++;
         end
         chk(n >= WC - 10 && n <= WC + 8, 1'h1);
         rel_len(n);
         chk(n >= RC && n <= RC + 8, 1'h1);
      end
      kick_en = 1'b1;
      lo = 0;
      for (k = 0; k < 3 * WC; k++) begin
         step(1);
         lo += (act !== 1'b0);
      end
      chk(lo, 0);
      {ce_cmd_n, sup, blo} = 3'h3;
      step(8);
      chk({flag, backed, act, ce_out_n}, 4'hf);
      {mr_n, aux, kick_en} = 3'h2;
      for (k = 0; k < 10; k++) begin
         ce_cmd_n = 1'($urandom);
         step(1);
         chk({flag, act, ce_out_n}, 3'h7);
      end
      {mr_n, aux, kick_en, blo} = 4'ha;
      step(6);
      chk({flag, backed, act}, 3'h1);
      sup = 1'b0;
      rel_len(n);
      chk(n >= RC && n <= RC + 8, 1'h1);
      step(5);
      report_and_stop();
   end
endmodule : supply_supervisor_reset_ce_gate_tb
